// *** src/fspl_core.sv ***
// Module: flash self-program sequencer with lock and fuse read-out over APB
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - Concurrently-readable region reads blocked during page erase or page write.
// - Busy flag high from erase or write store until re-enable or reset.
// - Re-enable command clears busy flag; software issues it first.
// - Lock write pattern X0001001 needs store within four cycles.
// - Zero bits 5..2 of work register program boot lock bits.
// - Address pointer ignored during lock write.
// - Lock programming keeps whole memory readable.
// - EEPROM write busy refuses flash programming.
// - EEPROM write busy refuses fuse and lock reads.
// - Pointer 1 with enables returns lock byte within three cycles.
// - Enables self-clear on read, load timeout or store timeout.
// - With enables clear, load returns ordinary memory data.
// - Lock byte: boot bits 5..2, general bits 1..0, 7..6 unused.
// - Pointer 0 returns fuse low byte.
// - Pointer 3 returns fuse high byte.
// - Pointer 2 returns extended fuse byte.
// - Programmed bits read zero, unprogrammed read one.
// - Reset does not abort a running flash write.
// - Writes timed from RC oscillator, 3.7 to 4.5 ms.
// - Only five legal low-bit patterns take effect.
// - Lock bits only programmed; erase needs chip erase.
module fspl_core #(
   parameter int PROG_TICKS = fspl_pkg::PROG_TICKS,
   parameter int RC_DIV     = fspl_pkg::RC_DIV
) (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 eeprom_write_busy,
   input  wire logic [7:0]           fuse_low_bits,
   input  wire logic [7:0]           fuse_high_bits,
   input  wire logic [7:0]           extended_fuse_bits,
   input  wire logic [1:0]           general_lock_bit,
   input  wire logic [7:0]           flash_read_data,
   input  wire logic                 chip_erase,
   output logic                      rww_read_block,
   output logic                      flash_busy
);
   // EEPROM busy and chip erase inputs pass two flops
   logic [1:0] ee_sync;
   logic [1:0] ce_sync;
   logic       ee_busy;
   logic       ce_req;
   always_ff @(posedge ref_clk) begin
      ee_sync <= {ee_sync[0], eeprom_write_busy};
      ce_sync <= {ce_sync[0], chip_erase};
   end
   assign ee_busy = ee_sync[1];
   assign ce_req  = ce_sync[1];

   // Software registers
   logic [15:0]              zptr;
   logic [7:0]               work;
   logic [7:0]               load_data;
   logic [3:0]               boot_lock_bits;
   logic                     store_program_enable;
   logic                     lock_fuse_access_bit;
   logic                     erase_bit;
   logic                     write_bit;
   logic                     rww_busy_flag;
   logic [2:0]               win_cnt;
   fspl_pkg::fspl_op_type    op;
   logic [31:0]              prog_cnt;
   logic [31:0]              div_cnt;

   wire        wr_acc   = psel & penable & pwrite;
   wire        rd_acc   = psel & penable & ~pwrite;
   wire        ctrl_wr  = wr_acc & (paddr == fspl_pkg::CTRL_OFS);
   wire        load_cmd = wr_acc & (paddr == fspl_pkg::LOAD_OFS) & pwdata[1];
   wire        store_cmd = wr_acc & (paddr == fspl_pkg::LOAD_OFS) & pwdata[0];
   wire [4:0]  pat      = pwdata[4:0];
   wire        busy_op  = (op != fspl_pkg::OP_IDLE);
   wire        rc_tick  = (div_cnt == 32'(RC_DIV - 1));
   wire        prog_done = busy_op & rc_tick & (prog_cnt == 32'(PROG_TICKS - 1));
   wire        armed    = (win_cnt != 3'h0);
   wire        lock_armed = armed & store_program_enable & lock_fuse_access_bit;

   wire pat_ok = (pat == fspl_pkg::PAT_RWWEN) | (pat == fspl_pkg::PAT_LOCK)
               | (pat == fspl_pkg::PAT_WRITE) | (pat == fspl_pkg::PAT_ERASE)
               | (pat == fspl_pkg::PAT_FILL);
   wire ctrl_take = ctrl_wr & pat_ok & ~ee_busy & ~busy_op;

   // lock/fuse read inside three-cycle window, refused while EEPROM busy
   wire fuse_rd   = load_cmd & lock_armed & (win_cnt > 3'h1) & ~ee_busy;
   wire store_go  = store_cmd & armed & store_program_enable & ~ee_busy;

   wire [7:0] lock_byte = {2'b11, boot_lock_bits, general_lock_bit};
   wire [7:0] fuse_sel =
      (zptr == fspl_pkg::Z_LOCK)      ? lock_byte :
      (zptr == fspl_pkg::Z_FUSE_LOW)  ? fuse_low_bits :
      (zptr == fspl_pkg::Z_FUSE_HIGH) ? fuse_high_bits :
      (zptr == fspl_pkg::Z_FUSE_EXT)  ? extended_fuse_bits : 8'hFF;

   // APB register writes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         zptr <= 16'h0000;
         work <= 8'hFF;
      end else if (wr_acc && paddr == fspl_pkg::ZPTR_OFS) begin
         zptr <= pwdata[15:0];
      end else if (wr_acc && paddr == fspl_pkg::WORK_OFS) begin
         work <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         load_data <= 8'h00;
      end else if (fuse_rd) begin
         load_data <= fuse_sel;
      end else if (load_cmd) begin
         load_data <= flash_read_data;
      end
   end

   // Timed enable window
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         win_cnt              <= 3'h0;
         store_program_enable <= 1'b0;
         lock_fuse_access_bit <= 1'b0;
         erase_bit            <= 1'b0;
         write_bit            <= 1'b0;
      end else if (ctrl_take) begin
         win_cnt              <= fspl_pkg::STORE_WIN;
         store_program_enable <= 1'b1;
         lock_fuse_access_bit <= pat[fspl_pkg::BIT_LOCK];
         erase_bit            <= pat[fspl_pkg::BIT_ERASE];
         write_bit            <= pat[fspl_pkg::BIT_WRITE];
      end else if (store_go || fuse_rd || (armed && win_cnt == 3'h1)) begin
         win_cnt              <= 3'h0;
         store_program_enable <= store_go & (erase_bit | write_bit);
         lock_fuse_access_bit <= 1'b0;
         if (!store_go) begin
            erase_bit <= 1'b0;
            write_bit <= 1'b0;
         end
      end else if (armed) begin
         win_cnt <= win_cnt - 3'h1;
      end else if (prog_done) begin
         store_program_enable <= 1'b0;
         erase_bit            <= 1'b0;
         write_bit            <= 1'b0;
      end
   end

   // reset leaves a running operation in place so it runs to completion
   always_ff @(posedge ref_clk) begin
      if (prog_done) begin
         op <= fspl_pkg::OP_IDLE;
      end else if (!nrst) begin
         // Reset clears only an idle or undefined op; a running write completes
         case (op)
            fspl_pkg::OP_ERASE, fspl_pkg::OP_WRITE, fspl_pkg::OP_LOCK: op <= op;
            default: op <= fspl_pkg::OP_IDLE;
         endcase
      end else if (store_go && !busy_op && lock_fuse_access_bit) begin
         op <= fspl_pkg::OP_LOCK;
      end else if (store_go && !busy_op && erase_bit) begin
         op <= fspl_pkg::OP_ERASE;
      end else if (store_go && !busy_op && write_bit) begin
         op <= fspl_pkg::OP_WRITE;
      end else if (!busy_op && !(op inside {fspl_pkg::OP_IDLE})) begin
         op <= fspl_pkg::OP_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!busy_op || rc_tick) begin
         div_cnt <= 32'h0;
      end else begin
         div_cnt <= div_cnt + 32'h1;
      end
      if (!busy_op || prog_done) begin
         prog_cnt <= 32'h0;
      end else if (rc_tick) begin
         prog_cnt <= prog_cnt + 32'h1;
      end
   end

   // zero work bits program boot lock; never unprogram by software
   always_ff @(posedge ref_clk) begin
      if (ce_req) begin
         boot_lock_bits <= fspl_pkg::LOCK_RESET[5:2];
      end else if (prog_done && op == fspl_pkg::OP_LOCK) begin
         boot_lock_bits <= boot_lock_bits & work[5:2];
      end
   end

   // busy flag set by erase/write, cleared by re-enable
   wire rww_clear = ctrl_take & (pat == fspl_pkg::PAT_RWWEN);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rww_busy_flag <= 1'b0;
      end else if (store_go && !lock_fuse_access_bit && (erase_bit || write_bit)) begin
         rww_busy_flag <= 1'b1;
      end else if (rww_clear) begin
         rww_busy_flag <= 1'b0;
      end
   end

   // block region during erase/write; lock write leaves it open
   assign rww_read_block = (op == fspl_pkg::OP_ERASE) | (op == fspl_pkg::OP_WRITE);
   assign flash_busy     = busy_op;

   // APB read mux
   wire [7:0] ctrl_rd = {1'b0, rww_busy_flag, 1'b0, 1'b0, lock_fuse_access_bit,
                         write_bit, erase_bit, store_program_enable};
   wire [31:0] rd_mux =
      (paddr == fspl_pkg::CTRL_OFS) ? {24'h0, ctrl_rd} :
      (paddr == fspl_pkg::ZPTR_OFS) ? {16'h0, zptr} :
      (paddr == fspl_pkg::WORK_OFS) ? {24'h0, work} :
      (paddr == fspl_pkg::LOAD_OFS) ? {24'h0, load_data} :
      (paddr == fspl_pkg::STAT_OFS) ? {30'h0, ee_busy, busy_op} :
      (paddr == fspl_pkg::FUSE_OFS) ? {24'h0, lock_byte} : 32'h0;
   wire mapped = (paddr <= fspl_pkg::FUSE_OFS) & (paddr[1:0] == 2'b00);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Assertions
   rww_block_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(rww_busy_flag) |=> rww_read_block) else $error("region not blocked");
   rww_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      rww_clear && !(store_go) |=> !rww_busy_flag) else $error("busy flag kept");
   win_timeout_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_take |-> ##[1:5] !armed) else $error("window too long");
   ee_refuse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_wr && ee_busy && !armed |=> !armed) else $error("ee busy accepted");
   ee_fuse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      ee_busy |-> !fuse_rd) else $error("fuse read during ee write");
   lock_open_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      op == fspl_pkg::OP_LOCK |-> !rww_read_block) else $error("lock blocked read");
   lock_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fuse_rd && zptr == fspl_pkg::Z_LOCK |=> load_data == {2'b11, $past(boot_lock_bits),
      $past(general_lock_bit)}) else $error("bad lock byte");
   lock_mono_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ce_req |=> (boot_lock_bits & ~$past(boot_lock_bits)) == 4'h0)
      else $error("lock bit unprogrammed");
endmodule : fspl_core

// *** src/fspl_pkg.sv ***
// Package: constants and carrier types for the flash self-program lock/fuse block
package fspl_pkg;
   // APB register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] ZPTR_OFS   = 8'h04;
   localparam logic [7:0] WORK_OFS   = 8'h08;
   localparam logic [7:0] LOAD_OFS   = 8'h0C;
   localparam logic [7:0] STAT_OFS   = 8'h10;
   localparam logic [7:0] FUSE_OFS   = 8'h14;
   // Control bit positions
   localparam int BIT_ENABLE  = 0;
   localparam int BIT_ERASE   = 1;
   localparam int BIT_WRITE   = 2;
   localparam int BIT_LOCK    = 3;
   localparam int BIT_RWWEN   = 4;
   localparam int BIT_BUSY    = 6;
   // Legal low-five patterns
   localparam logic [4:0] PAT_RWWEN = 5'h11;
   localparam logic [4:0] PAT_LOCK  = 5'h09;
   localparam logic [4:0] PAT_WRITE = 5'h05;
   localparam logic [4:0] PAT_ERASE = 5'h03;
   localparam logic [4:0] PAT_FILL  = 5'h01;
   // Lookup addresses
   localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
   localparam logic [15:0] Z_LOCK      = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   // Timed windows in cycles
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [2:0] LOAD_WIN  = 3'h3;
   // Reset values
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   // Programming time and oscillator
   localparam int PROG_MIN_US  = 3700;
   localparam int PROG_MAX_US  = 4500;
   localparam int RC_KHZ       = 1000;
   localparam int PROG_TICKS   = (PROG_MIN_US * RC_KHZ + 999) / 1000;
   localparam int CLK_MHZ      = 125;
   localparam int RC_DIV       = CLK_MHZ * 1000 / RC_KHZ;

   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_ERASE = 2'b01,
      OP_WRITE = 2'b10,
      OP_LOCK  = 2'b11
   } fspl_op_type;

   typedef struct packed {
      logic        store;
      logic        load;
      logic [15:0] zptr;
   } fspl_cpu_type;
endpackage : fspl_pkg

// *** dv/fspl_far_model.sv ***
// Far-side model: fuse store, lock pins, plain flash data and EEPROM busy
`timescale 1ns/1ns
module fspl_far_model (
   input  wire logic       ref_clk,
   input  wire logic       ee_req,
   input  wire logic       erase_req,
   output logic      [7:0] fuse_low_bits,
   output logic      [7:0] fuse_high_bits,
   output logic      [7:0] extended_fuse_bits,
   output logic      [1:0] general_lock_bit,
   output logic      [7:0] flash_read_data,
   output logic            eeprom_write_busy = 1'b0,
   output logic            chip_erase = 1'b0
);
   // Distinct bytes so a swapped pointer decode shows up
   // zero means programmed
   assign fuse_low_bits      = 8'hA1;
   assign fuse_high_bits     = 8'h3C;
   assign extended_fuse_bits = 8'hF6;
   assign general_lock_bit   = 2'h2;
   assign flash_read_data    = 8'h5A;
   always @(posedge ref_clk) begin
      eeprom_write_busy <= ee_req;
      chip_erase        <= erase_req;
   end
endmodule : fspl_far_model

// *** dv/tb.sv ***
// Self-checking bench for the self-program lock and fuse block
`timescale 1ns/1ns
module tb;
   logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, fl, fh, fe, fd;
   logic [31:0] pwdata, prdata, r;
   logic [1:0]  gl;
   logic        ee, ce, ee_req, erase_req, rww_read_block, flash_busy;
   int          fails, cmp_count, cyc, i;
   logic [15:0] zv [4] = '{16'h1, 16'h0, 16'h3, 16'h2};
   logic [31:0] mk [4] = '{32'h3F, 32'hFF, 32'hFF, 32'hFF};
   logic [31:0] ex [4] = '{32'h3E, 32'hA1, 32'h3C, 32'hF6};
   // Short program time keeps each operation near eight cycles
   fspl_core #(.PROG_TICKS(4), .RC_DIV(2)) uut (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_write_busy(ee),
      .fuse_low_bits(fl), .fuse_high_bits(fh), .extended_fuse_bits(fe),
      .general_lock_bit(gl), .flash_read_data(fd), .chip_erase(ce),
      .rww_read_block(rww_read_block), .flash_busy(flash_busy));
   fspl_far_model far (.ref_clk(ref_clk), .ee_req(ee_req), .erase_req(erase_req),
      .fuse_low_bits(fl), .fuse_high_bits(fh), .extended_fuse_bits(fe),
      .general_lock_bit(gl), .flash_read_data(fd), .eeprom_write_busy(ee),
      .chip_erase(ce));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize;
      $display("Compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_idle;
      int n;
      n = 0;
      while (flash_busy !== 1'b0 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      chk({31'h0, flash_busy}, 32'h0);
   endtask : wait_idle
   task automatic lock_op(input logic [31:0] work);
      apb(1'b1, fspl_pkg::WORK_OFS, work);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h09);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
   endtask : lock_op
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ee_req, erase_req} = '0;
      // Chip erase during reset gives the boot lock bits a known unprogrammed start
      erase_req = 1'b1;
      nrst = 1'b0;
      {fails, cmp_count, cyc} = '0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      erase_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // bench drives no interrupts, so nothing can reach the blocked region
      apb(1'b1, fspl_pkg::ZPTR_OFS, 32'h0);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h03);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
      #1 chk({31'h0, rww_read_block}, 32'h1);
      apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
      chk(r & 32'h40, 32'h40);
      wait_idle();
      apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
      chk(r & 32'h40, 32'h40);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h11);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
      apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
      chk(r & 32'h40, 32'h0);
      // Pointer loaded with junk, work bits 7,6,1,0 kept high
      apb(1'b1, fspl_pkg::ZPTR_OFS, 32'h1234);
      lock_op(32'hEB);
      #1 chk({31'h0, rww_read_block}, 32'h0);
      apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
      chk(r & 32'h40, 32'h0);
      wait_idle();
      apb(1'b0, fspl_pkg::FUSE_OFS, 32'h0);
      chk(r & 32'h3F, 32'h2A);
      lock_op(32'hFF);
      wait_idle();
      apb(1'b0, fspl_pkg::FUSE_OFS, 32'h0);
      chk(r & 32'h3F, 32'h2A);
      erase_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      erase_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, fspl_pkg::ZPTR_OFS, {16'h0, zv[i]});
         apb(1'b1, fspl_pkg::CTRL_OFS, 32'h09);
         apb(1'b1, fspl_pkg::LOAD_OFS, 32'h2);
         apb(1'b0, fspl_pkg::LOAD_OFS, 32'h0);
         chk(r & mk[i], ex[i]);
         apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
         chk(r & 32'h09, 32'h0);
      end
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h09);
      repeat (4) @(posedge ref_clk);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h2);
      apb(1'b0, fspl_pkg::LOAD_OFS, 32'h0);
      chk(r & 32'hFF, 32'h5A);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h03);
      repeat (5) @(posedge ref_clk);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
      apb(1'b0, fspl_pkg::STAT_OFS, 32'h0);
      chk(r & 32'h1, 32'h0);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h07);
      apb(1'b0, fspl_pkg::CTRL_OFS, 32'h0);
      chk(r & 32'h1F, 32'h0);
      ee_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, fspl_pkg::STAT_OFS, 32'h0);
      chk(r & 32'h2, 32'h2);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h03);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
      apb(1'b0, fspl_pkg::STAT_OFS, 32'h0);
      chk(r & 32'h1, 32'h0);
      apb(1'b1, fspl_pkg::ZPTR_OFS, 32'h0);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h09);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h2);
      apb(1'b0, fspl_pkg::LOAD_OFS, 32'h0);
      chk(r & 32'hFF, 32'h5A);
      ee_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      apb(1'b1, fspl_pkg::CTRL_OFS, 32'h03);
      apb(1'b1, fspl_pkg::LOAD_OFS, 32'h1);
      nrst <= 1'b0;
      @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      #1 chk({31'h0, flash_busy}, 32'h1);
      wait_idle();
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      summarize();
   end
endmodule : tb
